// ==== design/sync_serial_shift_port_pkg.sv ====
// shared constants of the synchronous serial shift port
package sync_serial_shift_port_pkg;

	// register port geometry
	localparam int addr_width = 3;
	localparam int data_width = 8;

	// register offsets on the plain register port
	localparam logic [2:0] addr_general_control_register = 3'h0;
	localparam logic [2:0] addr_processor_status_word = 3'h1;
	localparam logic [2:0] addr_port_data = 3'h2;
	localparam logic [2:0] addr_port_config = 3'h3;
	localparam logic [2:0] addr_serial_shift_register = 3'h4;

	// general control register fields
	localparam int pos_shift_rate_select_low = 0;
	localparam int pos_shift_rate_select_high = 1;
	localparam int pos_serial_port_select = 3;
	localparam int pos_done_irq_enable = 4;

	// status word fields
	localparam int pos_busy = 0;

	// port data and configuration fields
	localparam int pos_port_bit_four = 4;
	localparam int pos_port_bit_five = 5;
	localparam int pos_port_bit_six = 6;

	// reset values
	localparam logic [7:0] reset_general_control_register = 8'h00;
	localparam logic [7:0] reset_port_data = 8'h00;
	localparam logic [7:0] reset_port_config = 8'h00;
	localparam logic [7:0] reset_serial_shift_register = 8'h00;

	// master shift-clock periods in instruction cycles
	localparam int period_rate_code_0 = 2;
	localparam int period_rate_code_1 = 4;
	localparam int period_rate_code_2 = 8;

	// half periods in clock cycles, one clock is one instruction cycle
	localparam logic [2:0] half_rate_code_0 = 3'(period_rate_code_0 / 2);
	localparam logic [2:0] half_rate_code_1 = 3'(period_rate_code_1 / 2);
	localparam logic [2:0] half_rate_code_2 = 3'(period_rate_code_2 / 2);

	// bits in one frame and shift-clock edges in one frame
	localparam logic [3:0] bits_per_frame = 4'h8;
	localparam logic [4:0] edges_per_frame = 5'h10;

	// transfer state
	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_shift = 1'b1
	} xfer_state_t;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for pins arriving from outside the clock domain
module pin_sync #(
	parameter int width = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_en,
	input wire logic [width-1:0] d,
	output logic [width-1:0] q
);

	logic [width-1:0] stage_one;

	// the first stage is read only by the second
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage_one <= '0;
			q <= '0;
		end
		else if (clock_en)
		begin
			stage_one <= d;
			q <= stage_one;
		end
	end

endmodule
`default_nettype wire

// ==== design/sync_serial_shift_port.sv ====
// Contract
// - port works only while select bit is one; select routes out and clock pins
// - master clock period: code 00 two cycles, 01 four, 1x eight
// - writing busy one starts shifting; hardware clears busy after eight bits
// - software clearing busy stops shifting at once
// - with enable set, an interrupt request follows eight shifted bits
// - master generates the shift clock and starts every exchange
// - master needs serial-out and clock pins configured as outputs
// - slave takes external clock; clock pin input, serial-out output
// - clock config one selects internal clock; out config zero floats serial-out
// - slave clears busy and stops after eight external clock pulses
// - firmware sets busy right on entering slave mode
// - load the shift register only while the clock is idle
// - slave busy set during active clock phase may shorten first pulse
// - port data bit five selects the clock idle level
// - normal phase with idle level low samples on rising edge, shifts out on falling
// - alternate phase with idle level low samples on falling edge, shifts out on rising
// - config bit six holds phase select; zero normal, one alternate
// - phase select is zero after reset
// - phase equal to idle level: out on falling, in on rising; else reversed
// - one 8-bit shift register with serial in, serial out and clock pin
`timescale 1ns/100ps
`default_nettype none
module sync_serial_shift_port #(
	parameter int addr_width = sync_serial_shift_port_pkg::addr_width,
	parameter int data_width = sync_serial_shift_port_pkg::data_width
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_en,
	input wire logic [addr_width-1:0] reg_addr,
	input wire logic [data_width-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [data_width-1:0] reg_rdata,
	input wire logic sk_in,
	output logic sk_out,
	output logic sk_oe,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	output logic irq_request
);

	// software-visible control bits
	logic shift_rate_select_low;
	logic shift_rate_select_high;
	logic serial_port_select;
	logic done_irq_enable;
	logic port_bit_five;
	logic so_is_output;
	logic sk_is_output;
	logic clock_phase_alternate;

	// transfer state
	sync_serial_shift_port_pkg::xfer_state_t state;
	logic [data_width-1:0] serial_shift_register;
	logic [3:0] bit_cnt;
	logic pending;
	logic [data_width-1:0] rx_shift;
	logic [1:0] take_dly;
	logic take_now;

	// shift clock generation and edge detection
	logic [2:0] half_cnt;
	logic [2:0] half_limit;
	logic [4:0] toggles;
	logic sk_gen;
	logic sk_sync;
	logic si_sync;
	logic sk_level;
	logic sk_prev;
	logic rise;
	logic fall;
	logic sample_rising;
	logic leading_sample;
	logic sample_edge;
	logic out_edge;
	logic active;
	logic master;
	logic sample_ok;
	logic out_ok;
	logic sk_pin;
	logic finish;

	// register strobes
	logic wr_control;
	logic wr_status;
	logic wr_data;
	logic wr_config;
	logic wr_shift;
	logic next_busy_set;

	assign wr_control = reg_write
		&& (reg_addr == sync_serial_shift_port_pkg::addr_general_control_register);
	assign wr_status = reg_write
		&& (reg_addr == sync_serial_shift_port_pkg::addr_processor_status_word);
	assign wr_data = reg_write && (reg_addr == sync_serial_shift_port_pkg::addr_port_data);
	assign wr_config = reg_write && (reg_addr == sync_serial_shift_port_pkg::addr_port_config);
	assign wr_shift = reg_write
		&& (reg_addr == sync_serial_shift_port_pkg::addr_serial_shift_register);

	// busy can only be set while the port is selected
	assign next_busy_set = wr_status && reg_wdata[sync_serial_shift_port_pkg::pos_busy]
		&& serial_port_select;

	// pins from the far side pass two flip-flops before any logic looks at them
	pin_sync #(
		.width(2)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clock_en(clock_en),
		.d({sk_in, si}),
		.q({sk_sync, si_sync})
	);

	// control register: rate code, port select, completion interrupt enable
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_rate_select_low <= sync_serial_shift_port_pkg::reset_general_control_register[
				sync_serial_shift_port_pkg::pos_shift_rate_select_low];
			shift_rate_select_high <= sync_serial_shift_port_pkg::reset_general_control_register[
				sync_serial_shift_port_pkg::pos_shift_rate_select_high];
			serial_port_select <= sync_serial_shift_port_pkg::reset_general_control_register[
				sync_serial_shift_port_pkg::pos_serial_port_select];
			done_irq_enable <= sync_serial_shift_port_pkg::reset_general_control_register[
				sync_serial_shift_port_pkg::pos_done_irq_enable];
		end
		else if (clock_en && wr_control)
		begin
			shift_rate_select_low <= reg_wdata[sync_serial_shift_port_pkg::pos_shift_rate_select_low];
			shift_rate_select_high <= reg_wdata[sync_serial_shift_port_pkg::pos_shift_rate_select_high];
			serial_port_select <= reg_wdata[sync_serial_shift_port_pkg::pos_serial_port_select];
			done_irq_enable <= reg_wdata[sync_serial_shift_port_pkg::pos_done_irq_enable];
		end
	end

	// port data bit five: idle level of the shift clock
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			port_bit_five <= sync_serial_shift_port_pkg::reset_port_data[
				sync_serial_shift_port_pkg::pos_port_bit_five];
		else if (clock_en && wr_data)
			port_bit_five <= reg_wdata[sync_serial_shift_port_pkg::pos_port_bit_five];
	end

	// port configuration: pin directions and phase select, phase clears at reset
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			so_is_output <= sync_serial_shift_port_pkg::reset_port_config[
				sync_serial_shift_port_pkg::pos_port_bit_four];
			sk_is_output <= sync_serial_shift_port_pkg::reset_port_config[
				sync_serial_shift_port_pkg::pos_port_bit_five];
			clock_phase_alternate <= sync_serial_shift_port_pkg::reset_port_config[
				sync_serial_shift_port_pkg::pos_port_bit_six];
		end
		else if (clock_en && wr_config)
		begin
			so_is_output <= reg_wdata[sync_serial_shift_port_pkg::pos_port_bit_four];
			sk_is_output <= reg_wdata[sync_serial_shift_port_pkg::pos_port_bit_five];
			clock_phase_alternate <= reg_wdata[sync_serial_shift_port_pkg::pos_port_bit_six];
		end
	end

	// clock pin configured as output means internal clock, i.e. master
	assign master = sk_is_output;
	assign active = (state == sync_serial_shift_port_pkg::st_shift);

	// half period in clock cycles from the rate code, upper bit dominates
	always_comb
	begin
		if (shift_rate_select_high)
			half_limit = sync_serial_shift_port_pkg::half_rate_code_2;
		else if (shift_rate_select_low)
			half_limit = sync_serial_shift_port_pkg::half_rate_code_1;
		else
			half_limit = sync_serial_shift_port_pkg::half_rate_code_0;
	end

	// master clock: sixteen toggles then rest at idle; counting toggles
	// keeps a fast clock from starting a ninth pulse before the frame closes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			half_cnt <= 3'h0;
			toggles <= 5'h00;
			sk_gen <= 1'b0;
		end
		else if (clock_en)
		begin
			if (!active || !master)
			begin
				half_cnt <= 3'h0;
				toggles <= 5'h00;
				sk_gen <= port_bit_five;
			end
			else if (toggles < sync_serial_shift_port_pkg::edges_per_frame)
			begin
				if (half_cnt == half_limit - 3'h1)
				begin
					half_cnt <= 3'h0;
					sk_gen <= ~sk_gen;
					toggles <= toggles + 5'h01;
				end
				else
					half_cnt <= half_cnt + 3'h1;
			end
		end
	end

	// the clock seen by the shifter: own clock as master, pin clock as slave
	assign sk_level = master ? sk_gen : sk_sync;

	// previous clock level for edge detection; the pin copy of the own clock
	// moves in the cycle in which the shifter acts on that edge, so serial-out
	// never changes half a cycle after the pin edge the far side samples on
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sk_prev <= 1'b0;
			sk_pin <= 1'b0;
		end
		else if (clock_en)
		begin
			sk_prev <= sk_level;
			sk_pin <= sk_gen;
		end
	end

	assign rise = sk_level && !sk_prev;
	assign fall = !sk_level && sk_prev;

	// sampling edge: rising when phase select equals idle level
	assign sample_rising = (clock_phase_alternate == port_bit_five);
	assign sample_edge = sample_rising ? rise : fall;
	assign out_edge = sample_rising ? fall : rise;
	// leading edge leaves idle; it samples when its direction matches the sample edge
	assign leading_sample = sample_rising ^ port_bit_five;

	// edges that count: samples stop after eight bits, an output edge only
	// shifts once a sample has been taken since the last shift
	assign sample_ok = active && sample_edge
		&& (bit_cnt < sync_serial_shift_port_pkg::bits_per_frame);
	assign out_ok = active && out_edge && pending;

	// a master sees its own clock at once but the data pin two flops late,
	// so its captures wait two cycles; a slave sees both equally late
	assign take_now = master ? take_dly[1] : sample_ok;

	// end of frame: eight samples captured and, when the frame opens with a
	// sample, the closing output edge seen; in a slave a busy set mid-pulse
	// may see a shortened first pulse, firmware avoids that
	assign finish = active && (bit_cnt == sync_serial_shift_port_pkg::bits_per_frame)
		&& (take_dly == 2'h0) && !(leading_sample && pending);

	// delayed capture strobes of a master, dropped when a frame ends or aborts
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			take_dly <= 2'h0;
		else if (clock_en)
		begin
			if (!active)
				take_dly <= 2'h0;
			else
				take_dly <= {take_dly[0], sample_ok && master};
		end
	end

	// busy flag: software set wins over hardware clear in the same cycle;
	// deselecting the port aborts a frame
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state <= sync_serial_shift_port_pkg::st_idle;
		else if (clock_en)
		begin
			case (state)
				sync_serial_shift_port_pkg::st_idle:
				begin
					if (next_busy_set)
						state <= sync_serial_shift_port_pkg::st_shift;
				end
				sync_serial_shift_port_pkg::st_shift:
				begin
					if (next_busy_set)
						state <= sync_serial_shift_port_pkg::st_shift;
					else if (wr_status || !serial_port_select)
						state <= sync_serial_shift_port_pkg::st_idle;
					else if (finish)
						state <= sync_serial_shift_port_pkg::st_idle;
				end
				default:
					state <= sync_serial_shift_port_pkg::st_idle;
			endcase
		end
	end

	// shift register: load from software, shift out msb first on output
	// edges; captured bits collect at the bottom of a receive copy that
	// replaces the register when a full frame closes (an abort keeps it)
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_shift_register <= sync_serial_shift_port_pkg::reset_serial_shift_register;
			rx_shift <= sync_serial_shift_port_pkg::reset_serial_shift_register;
			bit_cnt <= 4'h0;
			pending <= 1'b0;
		end
		else if (clock_en)
		begin
			if (wr_shift)
				serial_shift_register <= reg_wdata;
			else if (finish)
				serial_shift_register <= rx_shift;
			else if (out_ok)
				serial_shift_register <= {serial_shift_register[data_width-2:0], 1'h0};
			if (take_now)
				rx_shift <= {rx_shift[data_width-2:0], si_sync};
			if (!active)
			begin
				bit_cnt <= 4'h0;
				pending <= 1'b0;
			end
			else if (sample_ok)
			begin
				bit_cnt <= bit_cnt + 4'h1;
				pending <= 1'b1;
			end
			else if (out_ok)
				pending <= 1'b0;
		end
	end

	// completion request: a one-cycle pulse, only for a full eight-bit frame
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq_request <= 1'b0;
		else if (clock_en)
			irq_request <= finish && done_irq_enable && !wr_status;
	end

	// pins: the shift register top bit drives serial-out; a zero direction
	// bit or a deselected port floats the pin
	assign so_out = serial_shift_register[data_width-1];
	assign so_oe = serial_port_select && so_is_output;
	assign sk_out = sk_pin;
	assign sk_oe = serial_port_select && sk_is_output;

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (clock_en)
		begin
			reg_rdata <= '0;
			if (reg_read)
			begin
				case (reg_addr)
					sync_serial_shift_port_pkg::addr_general_control_register:
					begin
						reg_rdata[sync_serial_shift_port_pkg::pos_shift_rate_select_low] <=
							shift_rate_select_low;
						reg_rdata[sync_serial_shift_port_pkg::pos_shift_rate_select_high] <=
							shift_rate_select_high;
						reg_rdata[sync_serial_shift_port_pkg::pos_serial_port_select] <=
							serial_port_select;
						reg_rdata[sync_serial_shift_port_pkg::pos_done_irq_enable] <= done_irq_enable;
					end
					sync_serial_shift_port_pkg::addr_processor_status_word:
						reg_rdata[sync_serial_shift_port_pkg::pos_busy] <= active;
					sync_serial_shift_port_pkg::addr_port_data:
						reg_rdata[sync_serial_shift_port_pkg::pos_port_bit_five] <= port_bit_five;
					sync_serial_shift_port_pkg::addr_port_config:
					begin
						reg_rdata[sync_serial_shift_port_pkg::pos_port_bit_four] <= so_is_output;
						reg_rdata[sync_serial_shift_port_pkg::pos_port_bit_five] <= sk_is_output;
						reg_rdata[sync_serial_shift_port_pkg::pos_port_bit_six] <=
							clock_phase_alternate;
					end
					sync_serial_shift_port_pkg::addr_serial_shift_register:
						reg_rdata <= serial_shift_register;
					default:
						reg_rdata <= '0;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ==== verification/sync_serial_shift_port_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// pin and register-port checks of the shift port
module sync_serial_shift_port_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_en,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic sk_in,
	input wire logic sk_out,
	input wire logic sk_oe,
	input wire logic si,
	input wire logic so_out,
	input wire logic so_oe,
	input wire logic irq_request
);
	logic [7:0] ctl;
	logic [7:0] pdat;
	logic [7:0] pcfg;
	// shadow copies of the settings, so pin checks can be tied to the writes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl <= 8'h00;
			pdat <= 8'h00;
			pcfg <= 8'h00;
		end
		else if (reg_write && clock_en)
		begin
			if (reg_addr == 3'h0)
				ctl <= reg_wdata & 8'h1B;
			if (reg_addr == 3'h2)
				pdat <= reg_wdata & 8'h20;
			if (reg_addr == 3'h3)
				pcfg <= reg_wdata & 8'h70;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_ctl_read;
		reg_read && reg_addr == 3'h0;
	endsequence
	sequence s_cfg_read;
		reg_read && reg_addr == 3'h3;
	endsequence
	a_read_control: assert property (s_ctl_read |=> reg_rdata == $past(ctl))
		else $error("control read differs");
	a_read_config: assert property (s_cfg_read |=> reg_rdata == $past(pcfg))
		else $error("config read differs");
	a_read_quiet: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside answer cycle");
	a_clock_drive: assert property (sk_oe == (ctl[3] && pcfg[5]))
		else $error("clock enable wrong");
	a_out_drive: assert property (so_oe == (ctl[3] && pcfg[4]))
		else $error("serial out enable wrong");
	a_rate_slow: assert property ($changed(sk_out) && sk_oe && ctl[1] |=> $stable(sk_out)[*3])
		else $error("slow clock half too short");
	a_rate_mid: assert property ($changed(sk_out) && sk_oe && ctl[1:0] == 2'h1 |=> $stable(sk_out))
		else $error("mid clock half too short");
	a_irq_once: assert property (irq_request |=> !irq_request)
		else $error("request longer than a pulse");
	a_irq_enabled: assert property (irq_request |-> ctl[4])
		else $error("request while disabled");
	a_irq_idle: assert property (irq_request && sk_oe |-> sk_out == pdat[5])
		else $error("request before clock idle");
endmodule
bind sync_serial_shift_port sync_serial_shift_port_sva u_sva (
	.clock(clock),
	.rst_n(rst_n),
	.clock_en(clock_en),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.sk_in(sk_in),
	.sk_out(sk_out),
	.sk_oe(sk_oe),
	.si(si),
	.so_out(so_out),
	.so_oe(so_oe),
	.irq_request(irq_request)
);
`default_nettype wire

// ==== verification/far_end.sv ====
`timescale 1ns/100ps
`default_nettype none
// far-end peripheral: msb first, captures on the sample edge
module far_end (
	input wire logic sk_line,
	input wire logic so,
	input wire logic sample_rising,
	output wire logic si,
	output var logic sk_drive
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	logic pending = 1'h0;
	initial sk_drive = 1'h0;
	assign si = tx[7];
	// shift only after a capture, so a leading output edge leaves bit 7 up
	always @(sk_line)
	begin
		if (sk_line === sample_rising)
		begin
			rx = {rx[6:0], so};
			pending = 1'h1;
		end
		else if (pending)
		begin
			tx = tx << 1;
			pending = 1'h0;
		end
	end
	task automatic load(input logic [7:0] d);
		tx = d;
		rx = 8'h00;
		pending = 1'h0;
	endtask
	task automatic park(input logic lvl);
		sk_drive = lvl;
	endtask
	// eight pulses at 80 ns; the clock stands at idle outside frames
	task automatic run;
		int k;
		#7;
		for (k = 0; k < 16; k++)
			#40 sk_drive = ~sk_drive;
	endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic samp_r = 1'h1;
	logic [7:0] reg_rdata, rdv;
	logic sk_out, sk_oe, so_out, so_oe, irq_request, prev_sk;
	wire logic si, sk_drive;
	wire logic sk_line = sk_oe ? sk_out : sk_drive;
	wire logic so_pin = so_oe ? so_out : 1'hz;
	logic [31:0] lfsr = 32'hfaca;
	int n_fail = 0;
	int checked = 0;
	int tog, gap, want, bad_gap, irqs, i;
	always #2 clock = ~clock;
	sync_serial_shift_port u_sync_serial_shift_port (
		.clock(clock),
		.rst_n(rst_n),
		.clock_en(1'h1),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.sk_in(sk_line),
		.sk_out(sk_out),
		.sk_oe(sk_oe),
		.si(si),
		.so_out(so_out),
		.so_oe(so_oe),
		.irq_request(irq_request)
	);
	far_end u_far_end (
		.sk_line(sk_line),
		.so(so_pin),
		.sample_rising(samp_r),
		.si(si),
		.sk_drive(sk_drive)
	);
	// counts clock toggles, odd spacings and request pulses
	always @(posedge clock)
	begin
		prev_sk <= sk_out;
		gap <= gap + 1;
		if (irq_request)
			irqs <= irqs + 1;
		if (sk_out !== prev_sk)
		begin
			tog <= tog + 1;
			gap <= 1;
			if (tog > 0 && gap != want)
				bad_gap <= bad_gap + 1;
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic int half(input logic [1:0] code);
		return (code[1] ? 8 : code[0] ? 4 : 2) / 2;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
		@(posedge clock);
	endtask
	task automatic rreg(input logic [2:0] a);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clock);
		reg_read <= 1'h0;
		@(posedge clock);
		rdv = reg_rdata;
	endtask
	// polls busy under a bound, then lets a late request pulse land
	task automatic wait_idle;
		int k;
		for (k = 0; k < 60; k++)
		begin
			rreg(3'h1);
			if (rdv[0] === 1'h0)
				break;
		end
		chk(rdv[0], 0);
		repeat (3) @(posedge clock);
	endtask
	task automatic finish_frame(input logic [7:0] exp_rx, input logic [7:0] theirs);
		wait_idle;
		chk(irqs, 1);
		chk(u_far_end.rx, exp_rx);
		rreg(3'h4);
		chk(rdv, theirs);
	endtask
	task automatic master(input logic [1:0] code, input logic alt, input logic idle);
		logic [7:0] mine;
		lfsr = nxt(lfsr);
		mine = lfsr[7:0];
		samp_r = (alt == idle);
		want = half(code);
		wr(3'h0, {6'h06, code});
		wr(3'h2, {2'h0, idle, 5'h00});
		wr(3'h3, {1'h0, alt, 1'h1, lfsr[16], 4'h0});
		wr(3'h4, mine);
		chk(sk_out, idle);
		chk(so_oe, lfsr[16]);
		u_far_end.load(lfsr[15:8]);
		tog = 0;
		bad_gap = 0;
		irqs = 0;
		wr(3'h1, 8'h01);
		finish_frame(lfsr[16] ? mine : 8'hZZ, lfsr[15:8]);
		chk(tog, 16);
		chk(bad_gap, 0);
	endtask
	task automatic slave(input logic alt, input logic idle);
		lfsr = nxt(lfsr);
		samp_r = (alt == idle);
		u_far_end.park(idle);
		wr(3'h0, 8'h18);
		wr(3'h2, {2'h0, idle, 5'h00});
		wr(3'h3, {1'h0, alt, 6'h10});
		wr(3'h4, lfsr[7:0]);
		chk(sk_oe, 0);
		u_far_end.load(lfsr[15:8]);
		irqs = 0;
		wr(3'h1, 8'h01);
		u_far_end.run;
		finish_frame(lfsr[7:0], lfsr[15:8]);
	endtask
	// abort in mid-frame while the clock is toggling; the frame must freeze short
	task automatic abort_case;
		int t;
		wr(3'h0, 8'h1A);
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h30);
		u_far_end.load(8'h00);
		tog = 0;
		irqs = 0;
		wr(3'h1, 8'h01);
		repeat (16) @(posedge clock);
		wr(3'h1, 8'h00);
		repeat (4) @(posedge clock);
		t = tog;
		repeat (60) @(posedge clock);
		chk(tog, t);
		chk(t < 16, 1);
		chk(irqs, 0);
		chk(sk_out, 0);
	endtask
	task automatic complete_run;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		complete_run;
	end
	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		for (i = 0; i < 8; i++)
		begin
			rreg(i[2:0]);
			chk(rdv, 0);
		end
		for (i = 0; i < 16; i++)
			master(i[3:2], i[1], i[0]);
		abort_case;
		for (i = 0; i < 4; i++)
			slave(i[1], i[0]);
		// deselected: pins float and a start request is dropped
		wr(3'h0, 8'h10);
		chk(sk_oe | so_oe, 0);
		wr(3'h1, 8'h01);
		rreg(3'h1);
		chk(rdv, 0);
		complete_run;
	end
endmodule
`default_nettype wire
